// File: acp_pkg.sv
// Purpose: Shared constants and types for the ATA card pin port
// Assumes: 125 MHz core clock, synchronous active-high reset
// Notes: Strobe timing counts derive from nanosecond figures below
package acp_pkg;
   localparam int ACP_CLK_PERIOD_NS = 8;
   localparam int ACP_SETUP_NS = 70;
   localparam int ACP_STROBE_NS = 165;
   localparam int ACP_HOLD_NS = 30;
   localparam int ACP_SETUP_CYC = (ACP_SETUP_NS + ACP_CLK_PERIOD_NS - 1) / ACP_CLK_PERIOD_NS;
   localparam int ACP_STROBE_CYC = (ACP_STROBE_NS + ACP_CLK_PERIOD_NS - 1) / ACP_CLK_PERIOD_NS;
   localparam int ACP_HOLD_CYC = (ACP_HOLD_NS + ACP_CLK_PERIOD_NS - 1) / ACP_CLK_PERIOD_NS;
   localparam int ACP_RESET_NS = 25000;
   localparam int ACP_RESET_CYC = (ACP_RESET_NS + ACP_CLK_PERIOD_NS - 1) / ACP_CLK_PERIOD_NS;
   localparam int ACP_DATA_W = 16;
   localparam int ACP_BYTE_W = 8;
   localparam int ACP_ADDR_W = 3;
   localparam int ACP_FIFO_DEPTH = 8;
   localparam int ACP_CNT_W = 16;
   localparam logic [ACP_CNT_W-1:0] ACP_CNT_ZERO = 16'h0000;

   typedef enum logic [1:0] {
      ACP_SEL_TASKFILE = 2'h0,
      ACP_SEL_ALT = 2'h1
   } acp_sel_t;

   typedef struct packed {
      logic write;
      logic wide;
      acp_sel_t sel;
      logic [ACP_ADDR_W-1:0] addr;
      logic [ACP_DATA_W-1:0] wdata;
   } acp_req_t;

   typedef enum logic [2:0] {
      ACP_IDLE = 3'b000,
      ACP_SETUP = 3'b001,
      ACP_STROBE = 3'b011,
      ACP_HOLD = 3'b010,
      ACP_RESET = 3'b110
   } acp_state_t;
endpackage : acp_pkg

// File: acp_fifo.sv
// Purpose: Synchronous FIFO buffering read data from the card
// Assumes: One clock, synchronous active-high reset
// Notes: Full and empty are exact; no write when full, no read when empty
`timescale 1ns/10ps
module acp_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0] wr_ptr_r;
   logic [AW-1:0] rd_ptr_r;
   logic [AW:0] count_r;
   logic push;
   logic pop;

   assign in_ready = (count_r != (AW+1)'(DEPTH));
   assign out_valid = (count_r != '0);
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_data = mem_r[rd_ptr_r];

   always_ff @(posedge clk) begin
      if (push) begin
         mem_r[wr_ptr_r] <= in_data;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r <= '0;
      end else begin
         if (push) begin
            wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
         end
         if (pop) begin
            rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
         end
         if (push && !pop) begin
            count_r <= count_r + 1'b1;
         end else if (pop && !push) begin
            count_r <= count_r - 1'b1;
         end
      end
   end
endmodule : acp_fifo

// File: acp_port.sv
// Purpose: Host-side pin engine for a parallel ATA card in direct IDE mode
// Assumes: 125 MHz CLOCK, synchronous RST, card pins asynchronous to CLOCK
// Notes: One access at a time; read data is buffered in an 8-word FIFO
// Functional notes
// R1 - Names ending _N are asserted low; other signals asserted high.
// R2 - Alternate card select is driven low when addressing through it.
// R3 - Task-file select is driven low for task-file accesses in direct IDE mode.
// R4 - Three register address outputs carry bits 2, 1 and 0 of the register.
// R5 - A high card interrupt input means a card interrupt is pending.
// R6 - Task-file accesses use data bits 7:0; data transfers use 15:0.
// R7 - Data lines are bidirectional, carrying upper and lower bytes.
// R8 - A high I/O ready input lets the current access complete.
// R9 - Card present when both detect inputs read low.
// R10 - Card reset output low resets the card; high in normal operation.
// R11 - Read strobe low during a read cycle, high otherwise.
// R12 - Write strobe low during a write cycle, high otherwise.
// R13 - Device drives data only while write strobe is asserted.
`timescale 1ns/10ps
module acp_port
   import acp_pkg::*;
#(
   parameter int RESET_CYC = ACP_RESET_CYC,
   parameter int FIFO_DEPTH = ACP_FIFO_DEPTH
) (
   input wire logic CLOCK,
   input wire logic RST,
   input wire logic REQ_VALID,
   output logic REQ_READY,
   input wire acp_req_t REQ,
   input wire logic CARD_RESET_REQ,
   output logic RD_VALID,
   input wire logic RD_READY,
   output logic [ACP_DATA_W-1:0] RD_DATA,
   output logic WR_DONE,
   output logic BUSY,
   output logic CARD_PRESENT,
   output logic CARD_IRQ_PENDING,
   output logic CARD_SELECT_ALT_N,
   output logic CARD_SELECT_TASKFILE_N,
   output logic CARD_REG_ADDR_2,
   output logic CARD_REG_ADDR_1,
   output logic CARD_REG_ADDR_0,
   output logic CARD_READ_STROBE_N,
   output logic CARD_WRITE_STROBE_N,
   output logic CARD_HW_RESET_N,
   input wire logic CARD_IRQ_IN,
   input wire logic CARD_IO_READY,
   input wire logic CARD_DETECT_A_N,
   input wire logic CARD_DETECT_B_N,
   input wire logic [ACP_BYTE_W-1:0] CARD_DATA_HI_IN,
   output logic [ACP_BYTE_W-1:0] CARD_DATA_HI_OUT,
   output logic CARD_DATA_HI_OE_N,
   input wire logic [ACP_BYTE_W-1:0] CARD_DATA_LO_IN,
   output logic [ACP_BYTE_W-1:0] CARD_DATA_LO_OUT,
   output logic CARD_DATA_LO_OE_N
);
   acp_state_t state_r;
   acp_req_t cur_r;
   logic [ACP_CNT_W-1:0] cnt_r;
   logic [3:0] irq_s1_r;
   logic [3:0] irq_s2_r;
   logic [ACP_DATA_W-1:0] din_s1_r;
   logic [ACP_DATA_W-1:0] din_s2_r;
   logic sel_alt_n_r;
   logic sel_tf_n_r;
   logic [ACP_ADDR_W-1:0] addr_r;
   logic rd_n_r;
   logic wr_n_r;
   logic rst_n_r;
   logic [ACP_DATA_W-1:0] dout_r;
   logic wr_done_r;
   logic cap_valid_r;
   logic [ACP_DATA_W-1:0] cap_data_r;
   logic fifo_in_ready;
   logic ready_s;
   logic cnt_zero;

   // Two-stage synchronisers for all asynchronous card inputs
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         irq_s1_r <= 4'h6;
         irq_s2_r <= 4'h6;
         din_s1_r <= 16'h0000;
         din_s2_r <= 16'h0000;
      end else begin
         irq_s1_r <= {CARD_IO_READY, CARD_DETECT_B_N, CARD_DETECT_A_N, CARD_IRQ_IN};
         irq_s2_r <= irq_s1_r;
         din_s1_r <= {CARD_DATA_HI_IN, CARD_DATA_LO_IN};
         din_s2_r <= din_s1_r;
      end
   end

   assign CARD_IRQ_PENDING = irq_s2_r[0]; // [R5] [R1]
   assign CARD_PRESENT = !irq_s2_r[1] && !irq_s2_r[2]; // [R9]
   assign ready_s = irq_s2_r[3]; // [R8]
   assign cnt_zero = (cnt_r == ACP_CNT_ZERO);

   // Only accept a new access when a read result has somewhere to go
   assign REQ_READY = (state_r == ACP_IDLE) && !CARD_RESET_REQ && fifo_in_ready && !cap_valid_r;
   assign BUSY = (state_r != ACP_IDLE);

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         state_r <= ACP_RESET;
         cnt_r <= ACP_CNT_W'(RESET_CYC);
         cur_r <= '0;
      end else begin
         case (state_r)
            ACP_IDLE: begin
               if (CARD_RESET_REQ) begin
                  state_r <= ACP_RESET;
                  cnt_r <= ACP_CNT_W'(RESET_CYC);
               end else if (REQ_VALID && REQ_READY) begin
                  cur_r <= REQ;
                  state_r <= ACP_SETUP;
                  cnt_r <= ACP_CNT_W'(ACP_SETUP_CYC - 1);
               end
            end
            ACP_SETUP: begin
               if (cnt_zero) begin
                  state_r <= ACP_STROBE;
                  cnt_r <= ACP_CNT_W'(ACP_STROBE_CYC - 1);
               end else begin
                  cnt_r <= cnt_r - 1'b1;
               end
            end
            ACP_STROBE: begin
               // Stretched by the card until it signals ready
               if (!cnt_zero) begin
                  cnt_r <= cnt_r - 1'b1;
               end else if (ready_s) begin // [R8]
                  state_r <= ACP_HOLD;
                  cnt_r <= ACP_CNT_W'(ACP_HOLD_CYC - 1);
               end
            end
            ACP_HOLD: begin
               if (cnt_zero) begin
                  state_r <= ACP_IDLE;
               end else begin
                  cnt_r <= cnt_r - 1'b1;
               end
            end
            ACP_RESET: begin
               if (cnt_zero) begin
                  state_r <= ACP_IDLE;
               end else begin
                  cnt_r <= cnt_r - 1'b1;
               end
            end
            default: begin
               state_r <= ACP_IDLE;
            end
         endcase
      end
   end

   // Pin outputs registered to keep them glitch free
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         sel_alt_n_r <= 1'b1;
         sel_tf_n_r <= 1'b1;
         addr_r <= 3'h0;
         rd_n_r <= 1'b1;
         wr_n_r <= 1'b1;
         rst_n_r <= 1'b0;
         dout_r <= 16'h0000;
      end else begin
         rst_n_r <= (state_r != ACP_RESET); // [R10]
         if (state_r == ACP_SETUP || state_r == ACP_STROBE || state_r == ACP_HOLD) begin
            sel_alt_n_r <= !(cur_r.sel == ACP_SEL_ALT); // [R2]
            sel_tf_n_r <= !(cur_r.sel == ACP_SEL_TASKFILE); // [R3]
            addr_r <= cur_r.addr; // [R4]
         end else begin
            sel_alt_n_r <= 1'b1;
            sel_tf_n_r <= 1'b1;
         end
         rd_n_r <= !(state_r == ACP_STROBE && !cur_r.write); // [R11]
         wr_n_r <= !(state_r == ACP_STROBE && cur_r.write); // [R12]
         dout_r <= cur_r.wide ? cur_r.wdata : {8'h00, cur_r.wdata[7:0]}; // [R6]
      end
   end

   assign CARD_SELECT_ALT_N = sel_alt_n_r;
   assign CARD_SELECT_TASKFILE_N = sel_tf_n_r;
   assign CARD_REG_ADDR_2 = addr_r[2];
   assign CARD_REG_ADDR_1 = addr_r[1];
   assign CARD_REG_ADDR_0 = addr_r[0];
   assign CARD_READ_STROBE_N = rd_n_r;
   assign CARD_WRITE_STROBE_N = wr_n_r;
   assign CARD_HW_RESET_N = rst_n_r;
   assign CARD_DATA_HI_OUT = dout_r[15:8]; // [R7]
   assign CARD_DATA_LO_OUT = dout_r[7:0];
   // Upper byte only driven on wide transfers
   assign CARD_DATA_HI_OE_N = wr_n_r || !cur_r.wide; // [R13] [R6]
   assign CARD_DATA_LO_OE_N = wr_n_r; // [R13]

   // Capture read data at the end of the strobe phase
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         cap_valid_r <= 1'b0;
         cap_data_r <= 16'h0000;
         wr_done_r <= 1'b0;
      end else begin
         wr_done_r <= (state_r == ACP_HOLD) && cnt_zero && cur_r.write;
         if (state_r == ACP_STROBE && cnt_zero && ready_s && !cur_r.write) begin
            cap_valid_r <= 1'b1;
            cap_data_r <= cur_r.wide ? din_s2_r : {8'h00, din_s2_r[7:0]}; // [R6] [R7]
         end else if (fifo_in_ready) begin
            cap_valid_r <= 1'b0;
         end
      end
   end

   assign WR_DONE = wr_done_r;

   acp_fifo #(
      .WIDTH(ACP_DATA_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(CLOCK),
      .rst(RST),
      .in_valid(cap_valid_r),
      .in_ready(fifo_in_ready),
      .in_data(cap_data_r),
      .out_valid(RD_VALID),
      .out_ready(RD_READY),
      .out_data(RD_DATA)
   );
endmodule : acp_port

// File: acp_port_checker.sv
// Purpose: Pin-level protocol checks for the card port
// Assumes: Bound to acp_port, single clock domain
// Notes: Synchronised inputs are held five samples before judging
`timescale 1ns/10ps
module acp_port_checker (
   input wire logic CLOCK,
   input wire logic RST,
   input wire logic WR_DONE,
   input wire logic CARD_PRESENT,
   input wire logic CARD_IRQ_PENDING,
   input wire logic CARD_SELECT_ALT_N,
   input wire logic CARD_SELECT_TASKFILE_N,
   input wire logic CARD_READ_STROBE_N,
   input wire logic CARD_WRITE_STROBE_N,
   input wire logic CARD_HW_RESET_N,
   input wire logic CARD_IRQ_IN,
   input wire logic CARD_IO_READY,
   input wire logic CARD_DETECT_A_N,
   input wire logic CARD_DETECT_B_N,
   input wire logic CARD_DATA_HI_OE_N,
   input wire logic CARD_DATA_LO_OE_N
);
   default clocking cb @(posedge CLOCK);
   endclocking
   default disable iff (RST);
   a_one_strobe: assert property (
      CARD_READ_STROBE_N || CARD_WRITE_STROBE_N) else $error("both strobes low");
   a_strobe_select: assert property (
      !(CARD_READ_STROBE_N && CARD_WRITE_STROBE_N) |->
      CARD_SELECT_ALT_N != CARD_SELECT_TASKFILE_N) else $error("select not unique");
   a_lo_drive: assert property (
      !CARD_DATA_LO_OE_N |-> !CARD_WRITE_STROBE_N) else $error("low byte driven idle");
   a_hi_drive: assert property (
      !CARD_DATA_HI_OE_N |-> !CARD_DATA_LO_OE_N) else $error("high byte alone");
   a_reset_quiet: assert property (
      !CARD_HW_RESET_N |-> CARD_READ_STROBE_N && CARD_WRITE_STROBE_N)
      else $error("strobe during card reset");
   a_detect_follow: assert property (
      $stable({CARD_DETECT_A_N, CARD_DETECT_B_N})[*4] |->
      CARD_PRESENT == (!CARD_DETECT_A_N && !CARD_DETECT_B_N)) else $error("presence wrong");
   a_irq_follow: assert property (
      $stable(CARD_IRQ_IN)[*4] |-> CARD_IRQ_PENDING == CARD_IRQ_IN) else $error("irq wrong");
   a_strobe_min: assert property (
      $fell(CARD_READ_STROBE_N) |=> !CARD_READ_STROBE_N[*8]) else $error("read strobe short");
   a_ready_wait: assert property (
      (!CARD_READ_STROBE_N && !CARD_IO_READY)[*4] |=> !CARD_READ_STROBE_N)
      else $error("strobe ended unready");
   a_write_done: assert property (
      $rose(CARD_WRITE_STROBE_N) |-> ##[1:10] WR_DONE) else $error("no write done");
endmodule : acp_port_checker
bind acp_port acp_port_checker i_acp_port_checker (.CLOCK(CLOCK), .RST(RST),
   .WR_DONE(WR_DONE), .CARD_PRESENT(CARD_PRESENT), .CARD_IRQ_PENDING(CARD_IRQ_PENDING),
   .CARD_SELECT_ALT_N(CARD_SELECT_ALT_N), .CARD_SELECT_TASKFILE_N(CARD_SELECT_TASKFILE_N),
   .CARD_READ_STROBE_N(CARD_READ_STROBE_N), .CARD_WRITE_STROBE_N(CARD_WRITE_STROBE_N),
   .CARD_HW_RESET_N(CARD_HW_RESET_N), .CARD_IRQ_IN(CARD_IRQ_IN),
   .CARD_IO_READY(CARD_IO_READY), .CARD_DETECT_A_N(CARD_DETECT_A_N),
   .CARD_DETECT_B_N(CARD_DETECT_B_N), .CARD_DATA_HI_OE_N(CARD_DATA_HI_OE_N),
   .CARD_DATA_LO_OE_N(CARD_DATA_LO_OE_N));

// File: acp_card_model.sv
// Purpose: Behavioural card on the far side of the port
// Assumes: Direct IDE mode, data lines with weak pull-downs
// Notes: Reads return a pattern built from the address pins
`timescale 1ns/10ps
module acp_card_model (
   input wire logic clk,
   input wire logic slow,
   input wire logic rd_n,
   input wire logic wr_n,
   input wire logic sel_alt_n,
   input wire logic sel_tf_n,
   input wire logic [2:0] addr,
   input wire logic [7:0] hi_out,
   input wire logic hi_oe_n,
   input wire logic [7:0] lo_out,
   input wire logic lo_oe_n,
   output logic [7:0] hi_in,
   output logic [7:0] lo_in,
   output logic io_ready,
   output logic [15:0] wdat,
   output logic [4:0] cap,
   output logic [31:0] wid
);
   logic rd_q = 1'b1;
   logic [31:0] acc_c = '0;
   logic rd_on;
   assign rd_on = !rd_n && !(sel_alt_n && sel_tf_n);
   // Released lines fall to the pull-down level, never hold the last value
   assign lo_in = rd_on ? {5'h06, addr} : (!lo_oe_n ? lo_out : 8'h00);
   assign hi_in = rd_on ? {5'h19, addr} : (!hi_oe_n ? hi_out : 8'h00);
   // Slow mode keeps the access waiting for 31 cycles
   assign io_ready = !slow || acc_c > 32'd30;
   always @(posedge clk) begin
      rd_q <= rd_n;
      acc_c <= (rd_n && wr_n) ? 32'd0 : acc_c + 32'd1;
      if (!rd_n)
         wid <= rd_q ? 32'd1 : wid + 32'd1;
      if (!wr_n) begin
         wdat <= {hi_in, lo_in};
         cap <= {sel_alt_n, sel_tf_n, addr};
      end
   end
endmodule : acp_card_model

// File: test_acp_port.sv
// Purpose: Self-checking bench for the card port
// Assumes: Card model answers reads with an address pattern
// Notes: Card reset shortened to a 5-cycle pulse (RESET_CYC of 4) to keep the run brief
`timescale 1ns/10ps
module test_acp_port;
   import acp_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic req_valid = 1'b0;
   logic rd_ready = 1'b0;
   logic card_rst_req = 1'b0;
   logic irq = 1'b0;
   logic det_a_n = 1'b0;
   logic det_b_n = 1'b0;
   logic slow = 1'b0;
   acp_req_t req = '0;
   logic req_ready, rd_valid, wr_done, busy, present, irq_pend, io_rdy;
   logic alt_n, tf_n, a2, a1, a0, rd_n, wr_n, hw_rst_n, hi_oe_n, lo_oe_n;
   logic [7:0] hi_in, hi_out, lo_in, lo_out;
   logic [15:0] rd_data, wdat;
   logic [4:0] cap;
   logic [31:0] wid;
   int miscompares = 0;
   int samples_checked = 0;
   int cyc = 0;
   acp_port #(.RESET_CYC(4)) i_acp_port (.CLOCK(clk), .RST(rst), .REQ_VALID(req_valid),
      .REQ_READY(req_ready), .REQ(req), .CARD_RESET_REQ(card_rst_req), .RD_VALID(rd_valid),
      .RD_READY(rd_ready), .RD_DATA(rd_data), .WR_DONE(wr_done), .BUSY(busy),
      .CARD_PRESENT(present), .CARD_IRQ_PENDING(irq_pend), .CARD_SELECT_ALT_N(alt_n),
      .CARD_SELECT_TASKFILE_N(tf_n), .CARD_REG_ADDR_2(a2), .CARD_REG_ADDR_1(a1),
      .CARD_REG_ADDR_0(a0), .CARD_READ_STROBE_N(rd_n), .CARD_WRITE_STROBE_N(wr_n),
      .CARD_HW_RESET_N(hw_rst_n), .CARD_IRQ_IN(irq), .CARD_IO_READY(io_rdy),
      .CARD_DETECT_A_N(det_a_n), .CARD_DETECT_B_N(det_b_n), .CARD_DATA_HI_IN(hi_in),
      .CARD_DATA_HI_OUT(hi_out), .CARD_DATA_HI_OE_N(hi_oe_n), .CARD_DATA_LO_IN(lo_in),
      .CARD_DATA_LO_OUT(lo_out), .CARD_DATA_LO_OE_N(lo_oe_n));
   acp_card_model i_acp_card_model (.clk(clk), .slow(slow), .rd_n(rd_n), .wr_n(wr_n),
      .sel_alt_n(alt_n), .sel_tf_n(tf_n), .addr({a2, a1, a0}), .hi_out(hi_out),
      .hi_oe_n(hi_oe_n), .lo_out(lo_out), .lo_oe_n(lo_oe_n), .hi_in(hi_in), .lo_in(lo_in),
      .io_ready(io_rdy), .wdat(wdat), .cap(cap), .wid(wid));
   always #4 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (cyc == 6000) begin
         miscompares++;
         stop_test();
      end
   end
   task automatic tick(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask : tick
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   function automatic logic [15:0] pat(input logic [2:0] a, input logic wd);
      return {wd ? {5'h19, a} : 8'h00, 5'h06, a};
   endfunction : pat
   task automatic issue(input logic w, input logic wd, input logic s, input logic [2:0] a,
         input logic [15:0] d);
      int n;
      req = '{w, wd, s ? ACP_SEL_ALT : ACP_SEL_TASKFILE, a, d};
      req_valid = 1'b1;
      for (n = 0; n < 199 && req_ready !== 1'b1; n++) tick(1);
      tick(1);
      req_valid = 1'b0;
      for (n = 0; n < 199 && (w ? wr_done : !busy) !== 1'b1; n++) tick(1);
   endtask : issue
   task automatic pop(input logic [15:0] e);
      int n;
      for (n = 0; n < 199 && rd_valid !== 1'b1; n++) tick(1);
      chk(rd_data, e);
      rd_ready = 1'b1;
      tick(1);
      rd_ready = 1'b0;
      // Let an edge pass so a following pop never re-raises ready in this step
      tick(1);
   endtask : pop
   task automatic t_write;
      logic [15:0] d;
      for (int i = 0; i < 16; i++) begin
         d = {8'h90 + i[7:0], 8'h30 + i[7:0]};
         issue(1'b1, i[3], i[0], i[2:0], d);
         chk(wdat, i[3] ? d : {8'h00, d[7:0]});
         chk(cap, {!i[0], i[0], i[2:0]});
      end
      $display("write test done");
   endtask : t_write
   task automatic t_read;
      for (int i = 0; i < 8; i++) issue(1'b0, i[0], i[1], 3'(7 - i), 16'h0000);
      chk(req_ready, 1'b0);
      for (int i = 0; i < 8; i++) pop(pat(3'(7 - i), i[0]));
      chk(rd_valid, 1'b0);
      chk(wid >= ACP_STROBE_CYC, 1'b1);
      $display("read buffer test done");
   endtask : t_read
   task automatic t_slow;
      slow = 1'b1;
      issue(1'b0, 1'b1, 1'b0, 3'h5, 16'h0000);
      slow = 1'b0;
      chk(wid > 32'd30, 1'b1);
      pop(pat(3'h5, 1'b1));
      $display("slow ready test done");
   endtask : t_slow
   task automatic t_pins;
      det_b_n = 1'b1;
      irq = 1'b1;
      tick(6);
      chk({present, irq_pend}, 2'h1);
      det_b_n = 1'b0;
      irq = 1'b0;
      tick(6);
      chk({present, irq_pend}, 2'h2);
      det_a_n = 1'b1;
      tick(6);
      chk(present, 1'b0);
      det_a_n = 1'b0;
      tick(6);
      chk(present, 1'b1);
      $display("pin input test done");
   endtask : t_pins
   task automatic t_crst;
      int n;
      card_rst_req = 1'b1;
      tick(1);
      card_rst_req = 1'b0;
      for (n = 0; n < 20 && hw_rst_n !== 1'b0; n++) tick(1);
      chk({busy, req_ready}, 2'h2);
      for (n = 0; n < 99 && hw_rst_n !== 1'b1; n++) tick(1);
      chk(n, 5);
      $display("card reset test done");
   endtask : t_crst
   task automatic stop_test;
      $display("compares %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : stop_test
   initial begin
      tick(3);
      chk(hw_rst_n, 1'b0);
      rst = 1'b0;
      for (int n = 0; n < 99 && req_ready !== 1'b1; n++) tick(1);
      // Pin outputs trail the state by one cycle
      tick(1);
      chk(hw_rst_n, 1'b1);
      t_write();
      t_read();
      t_slow();
      t_pins();
      t_crst();
      stop_test();
   end
endmodule : test_acp_port
